// *** design/csex_map.vh ***
// Constants for the strobe sequencer instruction executor
// Function
// - Aux decrement 0xBF, zero wraps to 0xFF
// - Count decrement 0xBE, zero wraps to 0xFF
// - Count increment 0xBD, 0xFF wraps to zero
// - Saturating increment gives min(count+1, M)
// - Random load masks count bits, zero/over-8 full
// - Back-to-back random loads reuse one value
// - Opcode 0xB9 sets program interrupt flag
// - Backoff countdown on overflows, then wait-done flag
// - Backoff zero at start means no wait
// - Fixed wait W overflows, zero means 32
// - Hold until timer reaches compare value
// - Label records next address, or own if last
// - Single loop start, replaced by each label
// - Repeat jumps to loop start on condition
// - Skip advances S plus one on condition
// - Skip of zero stalls until condition true
// - Decode all basic instruction types
// - Undefined opcodes execute as no-operation
// - Halt when program counter passes last location
// - Field positions of skip, repeat, wait, increment
`ifndef CSEX_MAP_VH
`define CSEX_MAP_VH

// ==========================================================================
// Register word offsets (address bits 7:2)
`define CSEX_OFF_CTRL 6'h00
`define CSEX_OFF_INSTR 6'h01
`define CSEX_OFF_BACKOFF 6'h02
`define CSEX_OFF_COUNT 6'h03
`define CSEX_OFF_AUX 6'h04
`define CSEX_OFF_TIMEOUT 6'h05
`define CSEX_OFF_STATUS 6'h06
`define CSEX_OFF_PC 6'h07

// ==========================================================================
// Field positions
`define CSEX_CTRL_START 0
`define CSEX_CTRL_STOP 1
`define CSEX_STAT_PROG_INT 0
`define CSEX_STAT_WAIT_DONE 1

// ==========================================================================
// Opcodes and reset values
`define CSEX_OP_AUX_DEC 8'hBF
`define CSEX_OP_CNT_DEC 8'hBE
`define CSEX_OP_CNT_INC 8'hBD
`define CSEX_OP_RAND 8'hBC
`define CSEX_OP_COUNTDOWN 8'hBB
`define CSEX_OP_LABEL 8'hBA
`define CSEX_OP_INT 8'hB9
`define CSEX_OP_CMP_HOLD 8'hB8
`define CSEX_OP_NOP 8'hC0
`define CSEX_WAIT_ZERO_CNT 6'h20
`define CSEX_RST_DATA 8'h00
`define CSEX_RST_TIMEOUT 8'hFF

`endif

// *** design/csex_imem.v ***
// Instruction memory with registered read data
`timescale 1ns/1ps
`include "csex_map.vh"
module csex_imem #(
    parameter DEPTH = 24,
    parameter AW = 5
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write port
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [7:0] wdata,
    // Read port
    input wire [AW-1:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    // ======================================================================
    // Storage, filled with no-operation after reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= `CSEX_OP_NOP;
            end
            rdata <= `CSEX_OP_NOP;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

// *** design/csex_randmask.v ***
// Random load masking of the backoff value
`timescale 1ns/1ps
module csex_randmask (
    // Inputs
    input wire [7:0] count,
    input wire [7:0] rnd,
    // Result
    output reg [7:0] loaded
);
    integer k;

    // ======================================================================
    // Keep the low count bits, clear the rest; a zero count keeps all bits
    always @* begin
        loaded = rnd;
        if (count != 8'h00 && count < 8'h08) begin
            for (k = 0; k < 8; k = k + 1) begin
                if (k >= count) begin
                    loaded[k] = 1'b0;
                end
            end
        end
    end
endmodule

// *** design/csex_executor.v ***
// Strobe sequencer instruction executor with APB register access
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "csex_map.vh"
module csex_executor #(
    parameter DEPTH = 24,
    parameter AW = 5,
    parameter TW = 16
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // MAC timer and random source
    input wire mac_overflow,
    input wire [TW-1:0] mac_timer_value,
    input wire [TW-1:0] timer_compare_register,
    input wire [7:0] random_source_output,
    input wire [7:0] condition_status,
    // Status towards the radio
    output reg program_interrupt_flag,
    output reg wait_done_flag,
    output reg running
);
    localparam ST_IDLE = 2'd0;
    localparam ST_FETCH = 2'd1;
    localparam ST_EXEC = 2'd2;
    localparam integer LAST_I = DEPTH - 1;
    localparam [AW:0] LAST = LAST_I[AW:0];
    localparam [AW:0] ONE_W = {{AW{1'b0}}, 1'b1};

    reg [1:0] state_reg;
    reg [AW-1:0] pc_reg;
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] loop_reg;
    reg loopv_reg;
    reg first_reg;
    reg [5:0] wcnt_reg;
    reg [7:0] backoff_reg;
    reg [7:0] count_reg;
    reg [7:0] aux_reg;
    reg [7:0] timeout_reg;
    reg [7:0] rnd_reg;
    reg rnd_used_reg;
    wire [7:0] instr;
    wire [7:0] rand_loaded;

    // ======================================================================
    // APB decode
    wire [5:0] widx = paddr[7:2];
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite;
    wire mapped = (widx <= `CSEX_OFF_PC);
    wire wr_ctrl = wr_acc && widx == `CSEX_OFF_CTRL;
    wire wr_instr = wr_acc && widx == `CSEX_OFF_INSTR;
    wire wr_backoff = wr_acc && widx == `CSEX_OFF_BACKOFF;
    wire wr_count = wr_acc && widx == `CSEX_OFF_COUNT;
    wire wr_aux = wr_acc && widx == `CSEX_OFF_AUX;
    wire wr_timeout = wr_acc && widx == `CSEX_OFF_TIMEOUT;
    wire wr_status = wr_acc && widx == `CSEX_OFF_STATUS;
    wire start_cmd = wr_ctrl && pwdata[`CSEX_CTRL_START];
    wire stop_cmd = wr_ctrl && pwdata[`CSEX_CTRL_STOP];
    // Loading during a run would corrupt the program, so it is dropped
    wire mem_we = wr_instr && !running;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    csex_imem #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_imem (
        .pclk(pclk),
        .presetn(presetn),
        .we(mem_we),
        .waddr(wptr_reg),
        .wdata(pwdata[7:0]),
        .raddr(pc_reg),
        .rdata(instr)
    );

    csex_randmask u_rand (
        .count(count_reg),
        .rnd(rnd_reg),
        .loaded(rand_loaded)
    );

    // ======================================================================
    // Instruction fields
    wire cond = condition_status[instr[2:0]] ^ instr[3];
    wire [2:0] skip_s = instr[6:4];
    wire [4:0] wait_w = instr[4:0];
    wire [7:0] sat_m = {5'h00, instr[2:0]};
    wire [8:0] count_inc = {1'b0, count_reg} + 9'h001;

    reg go;
    reg [AW:0] tgt;
    reg [5:0] cnt;
    reg [7:0] bo_next;
    reg [7:0] cn_next;
    reg [7:0] ax_next;
    reg [5:0] wcnt_next;
    reg [AW-1:0] loop_next;
    reg loopv_next;
    reg int_set;
    reg wt_set;
    reg rnd_use;

    // ======================================================================
    // Execute stage
    always @* begin
        go = 1'b0;
        tgt = {1'b0, pc_reg} + ONE_W;
        cnt = wcnt_reg;
        bo_next = backoff_reg;
        cn_next = count_reg;
        ax_next = aux_reg;
        wcnt_next = wcnt_reg;
        loop_next = loop_reg;
        loopv_next = loopv_reg;
        int_set = 1'b0;
        wt_set = 1'b0;
        rnd_use = 1'b0;
        if (state_reg == ST_EXEC) begin
            casez (instr)
                8'b0???????: begin
                    if (cond) begin
                        go = 1'b1;
                        tgt = {1'b0, pc_reg} + {{(AW-2){1'b0}}, skip_s} + ONE_W;
                    end else if (skip_s != 3'd0) begin
                        go = 1'b1;
                    end
                    // Zero skip with false condition stays here
                end
                8'b100?????: begin
                    if (first_reg) begin
                        cnt = (wait_w == 5'h00) ? `CSEX_WAIT_ZERO_CNT : {1'b0, wait_w};
                    end
                    wcnt_next = cnt;
                    if (mac_overflow) begin
                        if (cnt == 6'h01) begin
                            go = 1'b1;
                            wt_set = 1'b1;
                        end else begin
                            wcnt_next = cnt - 6'h01;
                        end
                    end
                end
                8'b1010????: begin
                    go = 1'b1;
                    if (cond && loopv_reg) begin
                        tgt = {1'b0, loop_reg};
                    end
                end
                8'b10110???: begin
                    go = 1'b1;
                    if (count_reg == 8'hFF || count_inc[7:0] > sat_m) begin
                        cn_next = sat_m;
                    end else begin
                        cn_next = count_inc[7:0];
                    end
                end
                `CSEX_OP_CMP_HOLD: begin
                    if (mac_timer_value >= timer_compare_register) begin
                        go = 1'b1;
                    end
                end
                `CSEX_OP_INT: begin
                    go = 1'b1;
                    int_set = 1'b1;
                end
                `CSEX_OP_LABEL: begin
                    go = 1'b1;
                    loopv_next = 1'b1;
                    if ({1'b0, pc_reg} == LAST) begin
                        loop_next = pc_reg;
                    end else begin
                        loop_next = pc_reg + {{(AW-1){1'b0}}, 1'b1};
                    end
                end
                `CSEX_OP_COUNTDOWN: begin
                    if (backoff_reg == 8'h00) begin
                        go = 1'b1;
                    end else if (mac_overflow) begin
                        bo_next = backoff_reg - 8'h01;
                        if (backoff_reg == 8'h01) begin
                            go = 1'b1;
                            wt_set = 1'b1;
                        end
                    end
                end
                `CSEX_OP_RAND: begin
                    go = 1'b1;
                    bo_next = rand_loaded;
                    rnd_use = 1'b1;
                end
                `CSEX_OP_CNT_INC: begin
                    go = 1'b1;
                    cn_next = count_reg + 8'h01;
                end
                `CSEX_OP_CNT_DEC: begin
                    go = 1'b1;
                    cn_next = count_reg - 8'h01;
                end
                `CSEX_OP_AUX_DEC: begin
                    go = 1'b1;
                    ax_next = aux_reg - 8'h01;
                end
                default: begin
                    go = 1'b1;
                end
            endcase
        end
    end

    // ======================================================================
    // Sequencer state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            pc_reg <= {AW{1'b0}};
            wptr_reg <= {AW{1'b0}};
            loop_reg <= {AW{1'b0}};
            loopv_reg <= 1'b0;
            first_reg <= 1'b0;
            wcnt_reg <= 6'h00;
            running <= 1'b0;
            rnd_reg <= 8'h00;
            rnd_used_reg <= 1'b0;
        end else begin
            loop_reg <= loop_next;
            loopv_reg <= loopv_next;
            wcnt_reg <= wcnt_next;
            first_reg <= 1'b0;
            // Source is frozen after a random load so a second one sees it too
            if (!rnd_used_reg && !rnd_use) begin
                rnd_reg <= random_source_output;
            end
            if (state_reg == ST_EXEC && go) begin
                rnd_used_reg <= rnd_use;
            end
            if (mem_we) begin
                wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (stop_cmd) begin
                state_reg <= ST_IDLE;
                running <= 1'b0;
                pc_reg <= {AW{1'b0}};
                wptr_reg <= {AW{1'b0}};
                loopv_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (start_cmd) begin
                            pc_reg <= {AW{1'b0}};
                            running <= 1'b1;
                            state_reg <= ST_FETCH;
                        end
                    end
                    ST_FETCH: begin
                        state_reg <= ST_EXEC;
                        first_reg <= 1'b1;
                    end
                    ST_EXEC: begin
                        if (go) begin
                            if (tgt > LAST) begin
                                state_reg <= ST_IDLE;
                                running <= 1'b0;
                            end else begin
                                pc_reg <= tgt[AW-1:0];
                                state_reg <= ST_FETCH;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        running <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Data registers and flags; host writes win over instruction updates of backoff, count and aux
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backoff_reg <= `CSEX_RST_DATA;
            count_reg <= `CSEX_RST_DATA;
            aux_reg <= `CSEX_RST_DATA;
            timeout_reg <= `CSEX_RST_TIMEOUT;
            program_interrupt_flag <= 1'b0;
            wait_done_flag <= 1'b0;
        end else begin
            backoff_reg <= wr_backoff ? pwdata[7:0] : bo_next;
            count_reg <= wr_count ? pwdata[7:0] : cn_next;
            aux_reg <= wr_aux ? pwdata[7:0] : ax_next;
            if (wr_timeout) begin
                timeout_reg <= pwdata[7:0];
            end
            // Set beats a clear in the same cycle
            if (int_set) begin
                program_interrupt_flag <= 1'b1;
            end else if (wr_status && pwdata[`CSEX_STAT_PROG_INT]) begin
                program_interrupt_flag <= 1'b0;
            end
            if (wt_set) begin
                wait_done_flag <= 1'b1;
            end else if (wr_status && pwdata[`CSEX_STAT_WAIT_DONE]) begin
                wait_done_flag <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Read data captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            case (widx)
                `CSEX_OFF_CTRL: prdata <= {31'h00000000, running};
                `CSEX_OFF_INSTR: prdata <= {24'h000000, running ? instr : `CSEX_OP_NOP};
                `CSEX_OFF_BACKOFF: prdata <= {24'h000000, backoff_reg};
                `CSEX_OFF_COUNT: prdata <= {24'h000000, count_reg};
                `CSEX_OFF_AUX: prdata <= {24'h000000, aux_reg};
                `CSEX_OFF_TIMEOUT: prdata <= {24'h000000, timeout_reg};
                `CSEX_OFF_STATUS: prdata <= {30'h00000000, wait_done_flag,
                                             program_interrupt_flag};
                `CSEX_OFF_PC: prdata <= {15'h0000, loopv_reg, {(8-AW){1'b0}}, loop_reg,
                                         {(8-AW){1'b0}}, pc_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// *** dv/csex_executor_assertions.sv ***
// Port-level checks for the strobe sequencer instruction executor
`timescale 1ns/1ps
module csex_executor_assertions #(
    parameter TW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Timer, random source and conditions
    input wire logic mac_overflow,
    input wire logic [TW-1:0] mac_timer_value,
    input wire logic [TW-1:0] timer_compare_register,
    input wire logic [7:0] random_source_output,
    input wire logic [7:0] condition_status,
    // Status
    input wire logic program_interrupt_flag,
    input wire logic wait_done_flag,
    input wire logic running
);
    // ==========================================================
    // Decoded bus phases
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire bad = paddr[7:5] != 3'h0;
    wire stw = acc && pwrite && paddr == 8'h18;
    wire ctw = acc && pwrite && paddr == 8'h00;

    // ==========================================================
    // Assertions
    slverr_map_a: assert property (pslverr == (acc && bad))
        else $error("pslverr does not match address decode");
    unmapped_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    status_read_a: assert property (acc && !pwrite && paddr == 8'h18 |->
        prdata == {30'h0, $past(wait_done_flag), $past(program_interrupt_flag)})
        else $error("status read disagrees with flags");
    int_clear_a: assert property ($fell(program_interrupt_flag) |-> $past(stw && pwdata[0]))
        else $error("interrupt flag dropped without clear");
    wait_clear_a: assert property ($fell(wait_done_flag) |-> $past(stw && pwdata[1]))
        else $error("wait flag dropped without clear");
    int_set_a: assert property ($rose(program_interrupt_flag) |-> $past(running))
        else $error("interrupt flag set while idle");
    wait_set_a: assert property ($rose(wait_done_flag) |-> $past(running))
        else $error("wait flag set while idle");
    run_start_a: assert property ($rose(running) |-> $past(ctw && pwdata[0]))
        else $error("execution began without start");
    run_two_a: assert property ($rose(running) |-> running [*2])
        else $error("instruction shorter than two cycles");
    run_stop_a: assert property (ctw && pwdata[1] && !pwdata[0] |=> !running)
        else $error("still running after stop");
endmodule

bind csex_executor csex_executor_assertions #(.TW(TW)) u_csex_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .mac_overflow(mac_overflow), .mac_timer_value(mac_timer_value),
    .timer_compare_register(timer_compare_register),
    .random_source_output(random_source_output), .condition_status(condition_status),
    .program_interrupt_flag(program_interrupt_flag), .wait_done_flag(wait_done_flag),
    .running(running)
);

// *** dv/csex_mac_model.sv ***
// MAC timer model: free-running count with one overflow pulse per wrap
`timescale 1ns/1ps
module csex_mac_model #(
    parameter PERIOD = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timer outputs
    output logic mac_overflow,
    output logic [15:0] mac_timer_value
);
    // ==========================================================
    // Short period keeps 32-overflow waits cheap
    wire wrap = mac_timer_value == 16'(PERIOD - 1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_timer_value <= 16'h0000;
            mac_overflow <= 1'b0;
        end else begin
            mac_overflow <= wrap;
            mac_timer_value <= wrap ? 16'h0000 : mac_timer_value + 16'h0001;
        end
    end
endmodule

// *** dv/csma_strobe_instruction_executor_bench.sv ***
// Self-checking bench for the strobe sequencer instruction executor
`timescale 1ns/1ps
`include "csex_map.vh"
module csma_strobe_instruction_executor_bench;
    // ==========================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf, pint, wdone, running, err;
    logic [7:0] paddr, rnd, cond;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] tval, cmp;
    logic [7:0] img [0:23];
    integer miscompares = 0;
    integer check_count = 0;
    integer n, i, j;
    localparam logic [7:0] rst_addr [7] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
    localparam logic [7:0] rst_val [7] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    csex_executor dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .mac_overflow(ovf), .mac_timer_value(tval), .timer_compare_register(cmp),
        .random_source_output(rnd), .condition_status(cond),
        .program_interrupt_flag(pint), .wait_done_flag(wdone), .running(running)
    );
    csex_mac_model timer (.pclk(pclk), .presetn(presetn), .mac_overflow(ovf),
        .mac_timer_value(tval));

    // ==========================================================
    // Tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // Entered and left just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            r = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task fresh;
        begin
            apb(1'b1, 8'h18, 32'h3);
            for (i = 0; i < 24; i = i + 1) img[i] = `CSEX_OP_NOP;
        end
    endtask

    // Whole image is rewritten: stop keeps old memory contents
    task run;
        begin
            apb(1'b1, 8'h00, 32'h2);
            for (i = 0; i < 24; i = i + 1) apb(1'b1, 8'h04, {24'h0, img[i]});
            apb(1'b1, 8'h00, 32'h1);
        end
    endtask

    task done;
        begin
            do @(posedge pclk); while (running !== 1'b0);
        end
    endtask

    task arith(input logic [7:0] wa, input logic [7:0] init, input logic [7:0] op,
        input logic [7:0] ra, input logic [7:0] exp);
        begin
            fresh;
            img[0] = op;
            apb(1'b1, wa, {24'h0, init});
            run;
            done;
            apb(1'b0, ra, 32'h0);
            chk(r, {24'h0, exp});
        end
    endtask

    // Counts overflow pulses seen in every cycle while running until the wait completes
    task cnt_wait(input logic [7:0] op, input logic [7:0] x, input integer exp);
        begin
            fresh;
            img[0] = op;
            apb(1'b1, 8'h08, {24'h0, x});
            run;
            n = 0;
            while (wdone !== 1'b1 && running === 1'b1) begin
                @(posedge pclk);
                if (ovf === 1'b1) n = n + 1;
                #1;
            end
            chk(wdone ? n : 0, exp);
            chk(wdone, exp != 0);
            done;
            apb(1'b0, 8'h08, 32'h0);
            chk(r, op == `CSEX_OP_COUNTDOWN ? 32'h0 : {24'h0, x});
        end
    endtask

    task hold(input logic [7:0] op);
        begin
            fresh;
            img[0] = op;
            img[1] = `CSEX_OP_INT;
            run;
            repeat (60) @(posedge pclk);
            chk(pint, 1'b0);
            apb(1'b0, 8'h1C, 32'h0);
            chk(r[4:0], 5'h00);
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks=%0d miscompares=%0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    initial begin
        #200000;
        miscompares = miscompares + 1;
        tally_and_finish;
    end

    // ==========================================================
    // Tests
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rnd = 8'hA5;
        cond = 8'h08;
        cmp = 16'h0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (j = 0; j < 7; j = j + 1) begin
            apb(1'b0, rst_addr[j], 32'h0);
            chk(r, {24'h0, rst_val[j]});
        end
        chk(err, 1'b1);
        for (j = 1; j < 5; j = j + 1) begin
            apb(1'b1, rst_addr[j], 32'hFFFFFF5A);
            apb(1'b0, rst_addr[j], 32'h0);
            chk(r, 32'h5A);
        end
        arith(8'h10, 8'h00, `CSEX_OP_AUX_DEC, 8'h10, 8'hFF);
        arith(8'h0C, 8'h00, `CSEX_OP_CNT_DEC, 8'h0C, 8'hFF);
        arith(8'h0C, 8'hFF, `CSEX_OP_CNT_INC, 8'h0C, 8'h00);
        arith(8'h0C, 8'hFF, 8'hB5, 8'h0C, 8'h05);
        arith(8'h0C, 8'h02, 8'hB5, 8'h0C, 8'h03);
        arith(8'h0C, 8'h05, 8'hB5, 8'h0C, 8'h05);
        arith(8'h0C, 8'h00, 8'hB7, 8'h0C, 8'h01);
        arith(8'h0C, 8'h03, `CSEX_OP_RAND, 8'h08, 8'h05);
        arith(8'h0C, 8'h00, `CSEX_OP_RAND, 8'h08, 8'hA5);
        arith(8'h0C, 8'h09, `CSEX_OP_RAND, 8'h08, 8'hA5);
        fresh;
        img[0] = `CSEX_OP_RAND;
        img[1] = `CSEX_OP_RAND;
        apb(1'b1, 8'h0C, 32'h8);
        run;
        rnd <= 8'h3C;
        done;
        apb(1'b0, 8'h08, 32'h0);
        chk(r, 32'hA5);
        fresh;
        img[0] = 8'hC5;
        img[1] = 8'hFF;
        img[2] = 8'hDF;
        img[3] = `CSEX_OP_INT;
        run;
        done;
        chk(pint, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, 8'h18, 32'h1);
        chk(pint, 1'b0);
        cnt_wait(8'h83, 8'h07, 3);
        cnt_wait(8'h80, 8'h07, 32);
        cnt_wait(`CSEX_OP_COUNTDOWN, 8'h02, 2);
        cnt_wait(`CSEX_OP_COUNTDOWN, 8'h00, 0);
        cmp <= 16'hFFFF;
        hold(`CSEX_OP_CMP_HOLD);
        cmp <= 16'h0000;
        done;
        chk(pint, 1'b1);
        cond <= 8'h00;
        hold(8'h04);
        cond <= 8'h10;
        done;
        chk(pint, 1'b1);
        cond <= 8'h08;
        for (j = 0; j < 2; j = j + 1) begin
            fresh;
            img[0] = {4'h2, j[0], 3'h3};
            img[1] = `CSEX_OP_INT;
            img[2] = `CSEX_OP_INT;
            img[3] = `CSEX_OP_CNT_INC;
            apb(1'b1, 8'h0C, 32'h0);
            run;
            done;
            chk(pint, j[0]);
            apb(1'b0, 8'h0C, 32'h0);
            chk(r, 32'h1);
        end
        fresh;
        img[22] = 8'h73;
        img[23] = `CSEX_OP_INT;
        run;
        done;
        chk(pint, 1'b0);
        fresh;
        img[0] = 8'hA3;
        img[1] = `CSEX_OP_INT;
        run;
        done;
        chk(pint, 1'b1);
        cond <= 8'h02;
        fresh;
        img[0] = `CSEX_OP_LABEL;
        img[1] = `CSEX_OP_CNT_INC;
        img[2] = 8'hA1;
        apb(1'b1, 8'h0C, 32'h0);
        run;
        repeat (60) @(posedge pclk);
        apb(1'b0, 8'h1C, 32'h0);
        chk(r[16:8], 9'h101);
        cond <= 8'h00;
        done;
        apb(1'b0, 8'h0C, 32'h0);
        chk(r > 32'h2, 1'b1);
        fresh;
        img[2] = `CSEX_OP_LABEL;
        img[23] = `CSEX_OP_LABEL;
        run;
        done;
        apb(1'b0, 8'h1C, 32'h0);
        chk(r[16:8], 9'h117);
        tally_and_finish;
    end
endmodule
